// ==== src/ews_clkdiv.sv ====
/*
 Phase clock enable generator.
 Assumes the oscillator is the single clock; bypass halves the rate.
*/
`timescale 1ns/10ps
module ews_clkdiv (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_bypass,
   output logic      o_phase_en
);
   logic toggle;

   // Half rate in bypass, full rate otherwise
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         toggle <= 1'b0;
      end else begin
         toggle <= ~toggle;
      end
   end

   assign o_phase_en = i_bypass ? toggle : 1'b1;

   bypass_half_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n)
      i_bypass && o_phase_en |=> !o_phase_en)
      else $error("bypass enable not at half rate");
endmodule

// ==== src/ews_pkg.sv ====
/*
 Constants for the external write strobe and address decode block.
 Assumes one 25 MHz clock, an active-low reset and synchronous inputs.
*/
// Operation
// - Single strobe goes low only during external memory writes.
// - Bit 2 of chip_config_0 picks single strobe at 1, low-byte at 0.
// - On 16-bit cycles the low-byte strobe fires for low and word writes.
// - Low-byte strobe on an 8-bit cycle fires for every external write.
// - Strobe pin held high in reset selects bypass clock mode at release.
// - In bypass mode the phase clocks run at half the oscillator rate.
// - CPU, peripheral and clock output timing derive from the oscillator.
// - After reset the first fetch address is 2080 hex.
// - Addresses 8000 to FFFF go to the external bus.
// - Addresses 0300 to 1EFF go to the external bus as reserved space.
// - Addresses 2080 to 7FFF decode as program memory.
// - Addresses 2000 to 207F decode as special-purpose memory.
// - 1F00-1FDF decode as peripheral SFRs, 1FE0-1FFF as memory-mapped SFRs.
// - 0100 to 02FF decode as upper register RAM.
// - 0000 to 00FF decode as the lower register file.
package ews_pkg;
   localparam int          STROBE_SEL_BIT = 2;
   localparam logic [15:0] RESET_FETCH    = 16'h2080;
   localparam logic [15:0] EXT_HI_LO      = 16'h8000;
   localparam logic [15:0] PROG_LO        = 16'h2080;
   localparam logic [15:0] SPECIAL_LO     = 16'h2000;
   localparam logic [15:0] MMSFR_LO       = 16'h1FE0;
   localparam logic [15:0] PSFR_LO        = 16'h1F00;
   localparam logic [15:0] EXPAN_LO       = 16'h0300;
   localparam logic [15:0] UPPER_LO       = 16'h0100;
   localparam logic [7:0]  CFG_RESET      = 8'hFF;

   typedef enum logic [2:0] {
      EWS_LOWER, EWS_UPPER, EWS_EXPAN, EWS_PSFR,
      EWS_MMSFR, EWS_SPECIAL, EWS_PROG, EWS_EXT_HI
   } ews_region_t;

   function automatic ews_region_t ews_decode(input logic [15:0] a);
      if (a >= EXT_HI_LO)       return EWS_EXT_HI;
      else if (a >= PROG_LO)    return EWS_PROG;
      else if (a >= SPECIAL_LO) return EWS_SPECIAL;
      else if (a >= MMSFR_LO)   return EWS_MMSFR;
      else if (a >= PSFR_LO)    return EWS_PSFR;
      else if (a >= EXPAN_LO)   return EWS_EXPAN;
      else if (a >= UPPER_LO)   return EWS_UPPER;
      else                      return EWS_LOWER;
   endfunction

   function automatic logic ews_is_external(input ews_region_t r);
      return (r == EWS_EXT_HI) || (r == EWS_EXPAN);
   endfunction
endpackage

// ==== src/ews_top.sv ====
/*
 External write strobe and address map decode.
 Assumes core access requests are synchronous to i_clk and that
 the strobe pin is three-stated during reset so the strap can be read.
*/
`timescale 1ns/10ps
module ews_top (
   input  wire logic                 i_clk,
   input  wire logic                 i_rstn,
   input  wire logic [7:0]           i_chip_config_0,
   input  wire logic                 i_acc_valid,
   input  wire logic                 i_acc_write,
   input  wire logic [15:0]          i_acc_addr,
   input  wire logic                 i_bus16,
   input  wire logic [1:0]           i_byte_en,
   input  wire logic                 i_strobe_pin_in,
   output logic                      o_strobe_pin_out,
   output logic                      o_strobe_pin_oe,
   output logic                      o_write_low_byte_strobe_n,
   output logic                      o_pll_bypass,
   output logic                      o_phase_en,
   output logic                      o_clock_output_pin,
   output logic                      o_ext_access,
   output ews_pkg::ews_region_t      o_region,
   output logic [15:0]               o_fetch_addr
);
   import ews_pkg::*;

   logic        rst_s1;
   logic        rst_n;
   logic        strap_done;
   logic        phase_en;
   logic        ext_write;
   logic        low_hit;
   logic        next_strobe_n;
   ews_region_t region;

   ////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Strap capture on the first clock after release
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done   <= 1'b0;
         o_pll_bypass <= 1'b0;
      end else if (!strap_done) begin
         strap_done   <= 1'b1;
         o_pll_bypass <= i_strobe_pin_in;
      end
   end

   ews_clkdiv u_div (
      .i_clk      (i_clk),
      .i_rst_n    (rst_n),
      .i_bypass   (o_pll_bypass),
      .o_phase_en (phase_en)
   );

   ////////////////////////////////////////////////////////////////////
   // Clock output and phase enable
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_phase_en         <= 1'b0;
         o_clock_output_pin <= 1'b0;
      end else begin
         o_phase_en <= phase_en;
         if (phase_en) begin
            o_clock_output_pin <= ~o_clock_output_pin;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address decode
   always_comb begin
      region    = ews_decode(i_acc_addr);
      ext_write = i_acc_valid && i_acc_write && ews_is_external(region);
      low_hit   = !i_bus16 || i_byte_en[0];
      if (i_chip_config_0[STROBE_SEL_BIT]) begin
         next_strobe_n = !ext_write;
      end else begin
         next_strobe_n = !(ext_write && low_hit);
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_region     <= EWS_LOWER;
         o_ext_access <= 1'b0;
         o_fetch_addr <= RESET_FETCH;
      end else begin
         o_region     <= region;
         o_ext_access <= i_acc_valid && ews_is_external(region);
         if (i_acc_valid) begin
            o_fetch_addr <= i_acc_addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Strobe pin, released during reset so the strap can be sensed
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_write_low_byte_strobe_n <= 1'b1;
         o_strobe_pin_out          <= 1'b1;
         o_strobe_pin_oe           <= 1'b0;
      end else begin
         o_write_low_byte_strobe_n <= next_strobe_n;
         o_strobe_pin_out          <= next_strobe_n;
         o_strobe_pin_oe           <= strap_done;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence ext_wr_s;
      i_acc_valid && i_acc_write && ews_is_external(ews_decode(i_acc_addr));
   endsequence

   sequence half_rate_s;
      !phase_en ##1 phase_en;
   endsequence

   // Region map and rate checks wait for strap_done, the first fully running cycle; most strobe checks use rst_n
   internal_quiet_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      !(i_acc_valid && i_acc_write && ews_is_external(ews_decode(i_acc_addr)))
      |=> o_write_low_byte_strobe_n)
      else $error("strobe low without external write");
   single_fire_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      ext_wr_s and i_chip_config_0[STROBE_SEL_BIT]
      |=> !o_write_low_byte_strobe_n)
      else $error("single strobe missed");
   high_only_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      ext_wr_s and !i_chip_config_0[STROBE_SEL_BIT] and i_bus16
      and i_byte_en == 2'b10 |=> o_write_low_byte_strobe_n)
      else $error("low strobe on high-byte write");
   word_fire_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      ext_wr_s and !i_chip_config_0[STROBE_SEL_BIT] and i_bus16
      and i_byte_en[0] |=> !o_write_low_byte_strobe_n)
      else $error("low or word write missed strobe");
   bus8_fire_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      ext_wr_s and !i_chip_config_0[STROBE_SEL_BIT] and !i_bus16
      |=> !o_write_low_byte_strobe_n)
      else $error("8-bit write missed strobe");
   idle_high_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      !i_acc_valid |=> o_write_low_byte_strobe_n && o_strobe_pin_out)
      else $error("strobe not resting high");
   strap_hold_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      strap_done |=> $stable(o_pll_bypass))
      else $error("bypass changed after strap");
   strap_release_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      !strap_done |-> !o_strobe_pin_oe)
      else $error("strobe pin driven before strap");
   pin_drive_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      strap_done |=> o_strobe_pin_oe
      && o_strobe_pin_out == o_write_low_byte_strobe_n)
      else $error("strobe pin not driven with strobe");
   fetch_reset_a: assert property (@(posedge i_clk)
      disable iff (!rst_n)
      !strap_done |-> o_fetch_addr == RESET_FETCH)
      else $error("bad reset fetch address");
   full_rate_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      !o_pll_bypass |-> phase_en)
      else $error("phase enable missing at full rate");
   bypass_rate_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      o_pll_bypass && phase_en |=> half_rate_s)
      else $error("phase enable not at half rate");
   clock_output_pin_toggle_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      phase_en |=> o_clock_output_pin != $past(o_clock_output_pin))
      else $error("clock output missed a phase");
   ext_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_valid && (i_acc_addr >= EXT_HI_LO
      || (i_acc_addr >= EXPAN_LO && i_acc_addr < PSFR_LO)) |=> o_ext_access)
      else $error("external range not routed");
   internal_local_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_valid && !ews_is_external(ews_decode(i_acc_addr))
      |=> !o_ext_access)
      else $error("internal access routed outside");
   sfr_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr >= PSFR_LO && i_acc_addr < MMSFR_LO |=> o_region == EWS_PSFR)
      else $error("peripheral SFR decode wrong");
   prog_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr >= PROG_LO && i_acc_addr < EXT_HI_LO
      |=> o_region == EWS_PROG)
      else $error("program decode wrong");
   lower_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr < UPPER_LO |=> o_region == EWS_LOWER)
      else $error("lower register decode wrong");
   upper_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr >= UPPER_LO && i_acc_addr < EXPAN_LO
      |=> o_region == EWS_UPPER)
      else $error("upper register decode wrong");
   expan_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr >= EXPAN_LO && i_acc_addr < PSFR_LO
      |=> o_region == EWS_EXPAN)
      else $error("expansion decode wrong");
   mmsfr_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr >= MMSFR_LO && i_acc_addr < SPECIAL_LO
      |=> o_region == EWS_MMSFR)
      else $error("memory-mapped SFR decode wrong");
   special_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr >= SPECIAL_LO && i_acc_addr < PROG_LO
      |=> o_region == EWS_SPECIAL)
      else $error("special-purpose decode wrong");
   exthi_map_a: assert property (@(posedge i_clk)
      disable iff (!strap_done)
      i_acc_addr >= EXT_HI_LO |=> o_region == EWS_EXT_HI)
      else $error("upper external decode wrong");
endmodule

// ==== verif/ews_ext_model.sv ====
/*
 External memory side of the shared strobe pin.
 Assumes it straps the pin only while the device releases it.
*/
`timescale 1ns/10ps
module ews_ext_model (
   input  wire logic i_strap,
   input  wire logic i_pin_out,
   input  wire logic i_pin_oe,
   output logic      o_pin
);
   always_comb begin
      if (i_pin_oe) o_pin = i_pin_out;
      else o_pin = i_strap; // Strap while released
   end
endmodule

// ==== verif/test_ews_top.sv ====
/*
 Self-checking bench for the strobe and address decode block.
 Assumes the external model straps the pin during reset.
*/
`timescale 1ns/10ps
module test_ews_top;
   import ews_pkg::*;
   logic        clk = 0, rstn = 0, strap = 0, valid = 0, wr = 0;
   logic        b16 = 0, pin, pout, poe, wrl_n, byp, ph, cko, ext;
   logic [7:0]  cfg = 8'hFF;
   logic [15:0] addr = 16'h0000, fetch;
   logic [1:0]  be = 2'h3;
   ews_region_t rgn;
   int          mismatches = 0, compares = 0, cyc = 0;
   initial forever #20 clk = ~clk;
   ews_top ews_top_inst (.i_clk(clk), .i_rstn(rstn),
      .i_chip_config_0(cfg), .i_acc_valid(valid), .i_acc_write(wr),
      .i_acc_addr(addr), .i_bus16(b16), .i_byte_en(be),
      .i_strobe_pin_in(pin), .o_strobe_pin_out(pout),
      .o_strobe_pin_oe(poe), .o_write_low_byte_strobe_n(wrl_n),
      .o_pll_bypass(byp), .o_phase_en(ph), .o_clock_output_pin(cko),
      .o_ext_access(ext), .o_region(rgn), .o_fetch_addr(fetch));
   ews_ext_model ews_ext_model_inst (.i_strap(strap), .i_pin_out(pout),
      .i_pin_oe(poe), .o_pin(pin));
   ////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic do_reset(input logic s);
      @(posedge clk);
      strap <= s;
      rstn <= 0;
      repeat (2) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      #1;
      cmp(poe, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      cmp(byp, s);
      cmp(poe, 1'b1);
      cmp(fetch, 16'h2080);
      cmp(wrl_n, 1'b1);
   endtask
   task automatic check_phase(input logic s);
      int n, t;
      logic c;
      n = 0;
      t = 0;
      c = cko;
      repeat (8) begin
         @(posedge clk);
         #1;
         n += (ph === 1'b1);
         t += (cko !== c);
         c = cko;
      end
      cmp(16'(n), 16'(s ? 4 : 8));
      cmp(16'(t), 16'(n));
   endtask
   task automatic acc(input logic w, input logic [15:0] a,
      input logic sel, input logic b, input logic [1:0] e,
      input logic exp_n);
      @(posedge clk);
      valid <= 1;
      wr <= w;
      addr <= a;
      cfg <= {5'h1F, sel, 2'h3};
      b16 <= b;
      be <= e;
      @(posedge clk);
      valid <= 0;
      #1;
      cmp(wrl_n, exp_n);
      cmp(pout, exp_n);
      cmp(ext, a >= 16'h8000 || (a >= 16'h0300 && a < 16'h1F00));
   endtask
   task automatic strobe_cases;
      acc(1, 16'h8000, 1, 1, 2'h2, 0);
      acc(1, 16'h0100, 1, 1, 2'h3, 1);
      acc(0, 16'hFFFF, 1, 1, 2'h3, 1);
      acc(1, 16'h0300, 1, 0, 2'h3, 0);
      acc(1, 16'h9000, 0, 1, 2'h1, 0);
      acc(1, 16'h9000, 0, 1, 2'h3, 0);
      acc(1, 16'h9000, 0, 1, 2'h2, 1);
      acc(1, 16'h1EFF, 0, 0, 2'h2, 0);
      acc(1, 16'h2080, 0, 0, 2'h1, 1);
      @(posedge clk);
      #1;
      cmp(wrl_n, 1'b1);
   endtask
   task automatic decode_cases;
      logic [15:0] t[16] = '{16'h0000, 16'h00FF, 16'h0100, 16'h02FF,
         16'h0300, 16'h1EFF, 16'h1F00, 16'h1FDF, 16'h1FE0, 16'h1FFF,
         16'h2000, 16'h207F, 16'h2080, 16'h7FFF, 16'h8000, 16'hFFFF};
      for (int i = 0; i < 16; i++) begin
         acc(0, t[i], 1, 1, 2'h3, 1);
         cmp(rgn, 16'(i / 2));
      end
   endtask
   initial begin
      do_reset(0);
      check_phase(0);
      strobe_cases();
      decode_cases();
      do_reset(1);
      check_phase(1);
      acc(1, 16'hC000, 1, 1, 2'h3, 0);
      give_verdict();
   end
endmodule
